/* File: acd_pkg.sv */
// Shared constants for the calibration datapath: register map, fields, resets, states.
// Assumes a single 125 MHz system clock and a word-addressed register port.
`default_nettype none
package acd_pkg;
  localparam int ACD_RAW_W = 24;
  localparam int ACD_OUT_W = 16;
  localparam int ACD_GAIN_FRAC = 23;
  localparam int ACD_ADDR_W = 3;
  // Register word addresses.
  localparam logic [2:0] ACD_ADDR_CTRL = 3'h0;
  localparam logic [2:0] ACD_ADDR_OFFSET = 3'h1;
  localparam logic [2:0] ACD_ADDR_GAIN = 3'h2;
  localparam logic [2:0] ACD_ADDR_DATA = 3'h3;
  localparam logic [2:0] ACD_ADDR_STATUS = 3'h4;
  // Control register fields.
  localparam int ACD_CTRL_AMP_LSB = 0;
  localparam int ACD_CTRL_UNI_BIT = 2;
  localparam int ACD_CTRL_CAL_LSB = 3;
  // Status register fields.
  localparam int ACD_STAT_NEW_BIT = 0;
  localparam int ACD_STAT_CAL_BIT = 1;
  localparam int ACD_STAT_DIV_BIT = 2;
  // Calibration kinds written into the control field.
  localparam logic [2:0] ACD_CAL_NONE = 3'h0;
  localparam logic [2:0] ACD_CAL_SELF_OFF = 3'h1;
  localparam logic [2:0] ACD_CAL_SELF_GAIN = 3'h2;
  localparam logic [2:0] ACD_CAL_SYS_OFF = 3'h3;
  localparam logic [2:0] ACD_CAL_SYS_GAIN = 3'h4;
  // Reset values.
  localparam logic [23:0] ACD_OFFSET_RST = 24'h000000;
  localparam logic [23:0] ACD_GAIN_RST = 24'h800000;
  localparam logic [23:0] ACD_GAIN_MAX = 24'hffffff;
  // Reciprocal divider: quotient of 2^46 takes 47 steps, counted down from 46.
  localparam logic [5:0] ACD_DIV_LAST = 6'h2e;
  typedef enum logic [1:0] {ACD_IDLE, ACD_CAL_WAIT, ACD_DIV} acd_state_t;
endpackage : acd_pkg
`default_nettype wire

/* File: acd_buf.sv */
// Small valid/ready buffer holding corrected results on their way out.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module acd_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  // Room exists while fewer than DEPTH words are held; an empty buffer must accept.
  assign in_ready_out = (count < (PW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : acd_buf
`default_nettype wire

/* File: acd_core.sv */
// Offset/gain correction and calibration stage after the decimation filter.
// Assumes raw results arrive as a valid/ready stream and software uses the register port.
//
// Behaviour
// - The raw filter result is a 24-bit signed value, always handled bipolar.
// - Offset and gain corrections are each held as 24-bit values.
// - After reset offset is zero and gain is unity.
// - Result is raw minus offset, times gain correction, times amplifier gain.
// - A two-bit control field selects the amplifier gain factor.
// - Unipolar mode clamps negatives to zero and doubles the result.
// - Self offset calibration shorts inputs and stores the raw result as offset.
// - Self gain calibration connects reference and stores reciprocal of raw minus offset.
// - System offset calibration needs a zero input from outside during measurement.
// - System gain calibration needs a full-scale input from outside during measurement.
// - System calibration writes offset and gain registers without host action.
// - Offset correction is read as two's complement.
// - Gain correction is unsigned with one integer and 23 fraction bits.
// - Data register changes only when a new conversion completes.
`timescale 1ns/1ps
`default_nettype none
module acd_core
  import acd_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic raw_valid_in,
  output logic raw_ready_out,
  input wire logic [ACD_RAW_W-1:0] raw_data_in,
  output logic res_valid_out,
  input wire logic res_ready_in,
  output logic [ACD_OUT_W-1:0] res_data_out,
  input wire logic [ACD_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic inputs_short_out,
  output logic ref_to_input_out,
  output logic sys_zero_req_out,
  output logic sys_full_req_out
);
  acd_state_t state;
  logic [1:0] programmable_amp;
  logic unipolar;
  logic [2:0] cal_kind;
  logic [23:0] offset_cal;
  logic [23:0] gain_cal;
  logic [15:0] conv_data;
  logic data_new;
  logic buf_in_ready;
  logic accept;
  logic conv_take;
  logic cal_take;
  logic is_gain_cal;
  logic ctrl_wr;
  logic [2:0] wr_cal;
  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic signed [30:0] shifted;
  logic signed [22:0] coarse;
  logic [2:0] shift_amt;
  logic [15:0] next_result;
  logic [23:0] div_d;
  logic [25:0] rem;
  logic [25:0] rem_sh;
  logic [23:0] quot;
  logic quot_ovf;
  logic [5:0] div_cnt;
  logic q_bit;

  assign accept = raw_valid_in & raw_ready_out;
  assign conv_take = accept & (state == ACD_IDLE);
  assign cal_take = accept & (state == ACD_CAL_WAIT);
  assign is_gain_cal = (cal_kind == ACD_CAL_SELF_GAIN) | (cal_kind == ACD_CAL_SYS_GAIN);
  assign ctrl_wr = reg_wr_in & (reg_addr_in == ACD_ADDR_CTRL);
  assign wr_cal = reg_wdata_in[ACD_CTRL_CAL_LSB +: 3];

  // A conversion sample is only taken when the result buffer has room, so a stalled reader loses nothing.
  assign raw_ready_out = ((state == ACD_IDLE) & buf_in_ready) | (state == ACD_CAL_WAIT);

  assign inputs_short_out = (state == ACD_CAL_WAIT) & (cal_kind == ACD_CAL_SELF_OFF);
  assign ref_to_input_out = (state == ACD_CAL_WAIT) & (cal_kind == ACD_CAL_SELF_GAIN);
  assign sys_zero_req_out = (state == ACD_CAL_WAIT) & (cal_kind == ACD_CAL_SYS_OFF);
  assign sys_full_req_out = (state == ACD_CAL_WAIT) & (cal_kind == ACD_CAL_SYS_GAIN);

  // Correction datapath; the sign of the raw word is kept whatever the output mode.
  always_comb begin
    diff = $signed({raw_data_in[23], raw_data_in}) - $signed({offset_cal[23], offset_cal});
    prod = diff * $signed({1'b0, gain_cal});
    shift_amt = {1'b0, programmable_amp} + {2'b00, unipolar};
    shifted = $signed({{4{prod[49]}}, prod[49:ACD_GAIN_FRAC]}) <<< shift_amt;
    coarse = shifted[30:8];
    if (unipolar) begin
      if (coarse[22]) begin
        next_result = 16'h0000;
      end else if (|coarse[21:16]) begin
        next_result = 16'hffff;
      end else begin
        next_result = coarse[15:0];
      end
    end else begin
      if (coarse[22:15] == {8{coarse[22]}}) begin
        next_result = coarse[15:0];
      end else begin
        next_result = coarse[22] ? 16'h8000 : 16'h7fff;
      end
    end
  end

  acd_buf #(
    .WIDTH(ACD_OUT_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .in_valid_in(conv_take),
    .in_ready_out(buf_in_ready),
    .in_data_in(next_result),
    .out_valid_out(res_valid_out),
    .out_ready_in(res_ready_in),
    .out_data_out(res_data_out)
  );

  // Sequencer: idle, waiting for a calibration sample, or forming a reciprocal.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ACD_IDLE;
      cal_kind <= ACD_CAL_NONE;
    end else begin
      case (state)
        ACD_IDLE: begin
          if (ctrl_wr && wr_cal != ACD_CAL_NONE && wr_cal <= ACD_CAL_SYS_GAIN) begin
            state <= ACD_CAL_WAIT;
            cal_kind <= wr_cal;
          end
        end
        ACD_CAL_WAIT: begin
          if (cal_take) begin
            if (is_gain_cal && !diff[24] && diff != '0) begin
              state <= ACD_DIV;
            end else begin
              state <= ACD_IDLE;
              cal_kind <= ACD_CAL_NONE;
            end
          end
        end
        ACD_DIV: begin
          if (div_cnt == '0) begin
            state <= ACD_IDLE;
            cal_kind <= ACD_CAL_NONE;
          end
        end
        default: begin
          state <= ACD_IDLE;
          cal_kind <= ACD_CAL_NONE;
        end
      endcase
    end
  end

  // Control bits are registered on a control-register write, so a change shows only in later results.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      programmable_amp <= 2'h0;
      unipolar <= 1'b0;
    end else if (ctrl_wr) begin
      programmable_amp <= reg_wdata_in[ACD_CTRL_AMP_LSB +: 2];
      unipolar <= reg_wdata_in[ACD_CTRL_UNI_BIT];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      offset_cal <= ACD_OFFSET_RST;
    end else if (cal_take && !is_gain_cal) begin
      offset_cal <= raw_data_in;
    end else if (reg_wr_in && reg_addr_in == ACD_ADDR_OFFSET) begin
      offset_cal <= reg_wdata_in[23:0];
    end
  end

  // Reciprocal by restoring division of 2^46 by the measured span; 1.0 lands on full scale.
  // The final step wraps the step counter, which is harmless since a new calibration reloads it.
  always_comb begin
    rem_sh = {rem[24:0], div_cnt == ACD_DIV_LAST};
    q_bit = (rem_sh >= {2'b00, div_d});
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_d <= '0;
      rem <= '0;
      quot <= '0;
      quot_ovf <= 1'b0;
      div_cnt <= '0;
    end else if (cal_take) begin
      div_d <= diff[23:0];
      rem <= '0;
      quot <= '0;
      quot_ovf <= 1'b0;
      div_cnt <= ACD_DIV_LAST;
    end else if (state == ACD_DIV) begin
      rem <= q_bit ? rem_sh - {2'b00, div_d} : rem_sh;
      quot <= {quot[22:0], q_bit};
      quot_ovf <= quot_ovf | quot[23];
      div_cnt <= div_cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gain_cal <= ACD_GAIN_RST;
    end else if (cal_take && is_gain_cal && (diff[24] || diff == '0)) begin
      gain_cal <= ACD_GAIN_MAX;
    end else if (state == ACD_DIV && div_cnt == '0) begin
      gain_cal <= (quot_ovf | quot[23]) ? ACD_GAIN_MAX : {quot[22:0], q_bit};
    end else if (reg_wr_in && reg_addr_in == ACD_ADDR_GAIN) begin
      gain_cal <= reg_wdata_in[23:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conv_data <= '0;
    end else if (conv_take) begin
      conv_data <= next_result;
    end
  end

  // A completing conversion wins over a read that would clear the flag in the same cycle.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_new <= 1'b0;
    end else if (conv_take) begin
      data_new <= 1'b1;
    end else if (reg_rd_in && reg_addr_in == ACD_ADDR_DATA) begin
      data_new <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        ACD_ADDR_CTRL: reg_rdata_out <= {26'h0, cal_kind, unipolar, programmable_amp};
        ACD_ADDR_OFFSET: reg_rdata_out <= {8'h00, offset_cal};
        ACD_ADDR_GAIN: reg_rdata_out <= {8'h00, gain_cal};
        ACD_ADDR_DATA: reg_rdata_out <= {16'h0000, conv_data};
        ACD_ADDR_STATUS: reg_rdata_out <= {29'h0, state == ACD_DIV, state != ACD_IDLE, data_new};
        default: reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // Checks.
  logic signed [24:0] chk_diff;
  assign chk_diff = diff;

  reset_values_a: assert property (@(posedge sys_clk_in)
    $rose(rst_b_in) |-> offset_cal == ACD_OFFSET_RST && gain_cal == ACD_GAIN_RST)
    else $error("Calibration registers not at reset values.");

  self_offset_store_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    cal_take && cal_kind == ACD_CAL_SELF_OFF |=> offset_cal == $past(raw_data_in))
    else $error("Self offset calibration did not store the raw sample.");

  sys_offset_store_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    cal_take && cal_kind == ACD_CAL_SYS_OFF |=> offset_cal == $past(raw_data_in)
      && state == ACD_IDLE)
    else $error("System offset calibration did not store the raw sample.");

  short_only_cal_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    inputs_short_out |-> state == ACD_CAL_WAIT && !ref_to_input_out)
    else $error("Inputs shorted outside self offset calibration.");

  data_stable_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !conv_take |=> $stable(conv_data))
    else $error("Data register changed without a conversion.");

  unipolar_clamp_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    conv_take && unipolar && chk_diff < 0 |=> conv_data == 16'h0000)
    else $error("Negative unipolar result not clamped to zero.");

  unity_pass_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    conv_take && !unipolar && programmable_amp == 2'h0 && offset_cal == '0
      && gain_cal == ACD_GAIN_RST |=> conv_data == $past(raw_data_in[23:8]))
    else $error("Unity correction did not pass the raw value.");

  gain_eight_sat_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    conv_take && !unipolar && programmable_amp == 2'h3 && gain_cal == ACD_GAIN_RST
      && chk_diff > 25'sh0100000 |=> conv_data == 16'h7fff)
    else $error("Bipolar result above range not saturated.");

  div_length_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $rose(state == ACD_DIV) |-> ##46 state == ACD_DIV ##1 state == ACD_IDLE)
    else $error("Reciprocal did not finish in 47 cycles.");

  stall_guard_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    res_valid_out && !res_ready_in |=> res_valid_out
      && res_data_out == $past(res_data_out))
    else $error("Held result changed while the reader stalled.");

  gain_max_store_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    cal_take && is_gain_cal && chk_diff <= 0 |=> gain_cal == ACD_GAIN_MAX)
    else $error("Nonpositive gain span did not store the largest gain.");

  cal_req_drop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    cal_take |=> !inputs_short_out && !ref_to_input_out && !sys_zero_req_out
      && !sys_full_req_out)
    else $error("Calibration request still raised after its sample.");

  amp_two_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    conv_take && !unipolar && programmable_amp == 2'h1 && offset_cal == '0
      && gain_cal == ACD_GAIN_RST && raw_data_in[23] == raw_data_in[22]
      |=> conv_data == $past(raw_data_in[22:7]))
    else $error("Amplifier code one did not double the result.");

  div_refuse_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    state == ACD_DIV |-> !raw_ready_out)
    else $error("Sample accepted while the reciprocal was running.");

  rdata_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !reg_rd_in |=> reg_rdata_out == '0)
    else $error("Read data did not return to zero after its cycle.");

  self_gain_cal_c: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    state == ACD_DIV && div_cnt == '0);
  unipolar_conv_c: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    conv_take && unipolar);
  stall_full_c: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    raw_valid_in && !raw_ready_out && state == ACD_IDLE);
  sys_offset_cal_c: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    cal_take && cal_kind == ACD_CAL_SYS_OFF);
  stalled_result_c: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    res_valid_out && !res_ready_in);
endmodule : acd_core
`default_nettype wire

/* File: acd_filt_model.sv */
// Behavioural decimation filter that feeds raw words into the calibration datapath.
// Assumes the bench pushes stream words and sets the levels used during calibration.
`timescale 1ns/1ps
`default_nettype none
module acd_filt_model (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic push_in,
  input wire logic [23:0] push_data_in,
  input wire logic gap_in,
  input wire logic zero_cond_in,
  input wire logic full_cond_in,
  input wire logic [23:0] zero_val_in,
  input wire logic [23:0] full_val_in,
  input wire logic raw_ready_in,
  output logic raw_valid_out,
  output logic [23:0] raw_data_out
);
  logic [23:0] q[$];
  logic from_cal;
  logic took;
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      raw_valid_out <= 1'b0;
      raw_data_out <= 24'h000000;
      from_cal = 1'b0;
    end else begin
      took = raw_valid_out && raw_ready_in;
      if (push_in) q.push_back(push_data_in);
      if (took && !from_cal) void'(q.pop_front());
      // A calibration word is withdrawn after one transfer, since the request falls late.
      if (took && (from_cal || gap_in)) begin
        raw_valid_out <= 1'b0;
        raw_data_out <= ~raw_data_out;
        from_cal = 1'b0;
      end else if (zero_cond_in || full_cond_in) begin
        raw_valid_out <= 1'b1;
        raw_data_out <= zero_cond_in ? zero_val_in : full_val_in;
        from_cal = 1'b1;
      end else if (q.size() > 0) begin
        raw_valid_out <= 1'b1;
        raw_data_out <= q[0];
        from_cal = 1'b0;
      end else begin
        raw_valid_out <= 1'b0;
        raw_data_out <= ~raw_data_out;
      end
    end
  end
endmodule : acd_filt_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the calibration datapath with a filter model upstream.
// Assumes the package, the core, its buffer and the filter model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t %s got %h exp %h", $time, m, g, e); end end
module tb_top;
  import acd_pkg::*;
  logic sys_clk, rst_b, raw_valid, raw_ready, res_valid, reg_wr, reg_rd, push, gap, stall;
  logic shorted, ref_on, zero_req, full_req, c_uni;
  logic res_ready = 1'b0;
  logic [23:0] raw_data, push_data, zero_val, full_val, c_gain;
  logic signed [23:0] c_off;
  logic [15:0] res_data, ev, last;
  logic [1:0] c_code;
  logic [2:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [15:0] exp_q[$];
  integer mismatches = 0;
  integer total_checks = 0;
  integer seed = 32'h67cb;
  longint span;
  acd_core u_acd_core (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .raw_valid_in(raw_valid),
    .raw_ready_out(raw_ready), .raw_data_in(raw_data), .res_valid_out(res_valid),
    .res_ready_in(res_ready), .res_data_out(res_data), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
    .inputs_short_out(shorted), .ref_to_input_out(ref_on), .sys_zero_req_out(zero_req),
    .sys_full_req_out(full_req));
  acd_filt_model u_acd_filt_model (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .push_in(push),
    .push_data_in(push_data), .gap_in(gap), .zero_cond_in(shorted || zero_req),
    .full_cond_in(ref_on || full_req), .zero_val_in(zero_val), .full_val_in(full_val),
    .raw_ready_in(raw_ready), .raw_valid_out(raw_valid), .raw_data_out(raw_data));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) res_ready <= !stall && (($random(seed) % 4) != 0);
  always @(posedge sys_clk) begin
    if (rst_b && res_valid && res_ready) begin
      if (exp_q.size() == 0) begin
        `CHK(1'b1, 1'b0, "extra result")
      end else begin
        ev = exp_q.pop_front();
        `CHK(res_data, ev, "result")
      end
    end
  end
  function automatic logic [15:0] exp_res(input logic [23:0] r);
    longint p;
    p = (longint'(signed'(r)) - longint'(c_off)) * longint'(c_gain);
    p = ((p >>> 23) <<< (int'(c_code) + int'(c_uni))) >>> 8;
    if (c_uni) return (p < 0) ? 16'h0000 : ((p > 65535) ? 16'hffff : p[15:0]);
    return (p < -32768) ? 16'h8000 : ((p > 32767) ? 16'h7fff : p[15:0]);
  endfunction : exp_res
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // Each bus task ends one edge late so no strobe is assigned twice in one step.
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [2:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    rv = reg_rdata;
  endtask : rd
  task automatic send(input logic [23:0] r);
    push <= 1'b1;
    push_data <= r;
    last = exp_res(r);
    exp_q.push_back(last);
    @(posedge sys_clk);
    push <= 1'b0;
    @(posedge sys_clk);
  endtask : send
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) begin
      `CHK(1'b1, 1'b0, "drain timeout")
      test_done();
    end
    repeat (3) @(posedge sys_clk);
  endtask : drain
  task automatic cal(input logic [2:0] k, input logic [23:0] zv, input logic [23:0] fv);
    int n;
    logic [3:0] req;
    zero_val <= zv;
    full_val <= fv;
    wr(ACD_ADDR_CTRL, {26'h0, k, c_uni, c_code});
    req = {k == ACD_CAL_SELF_OFF, k == ACD_CAL_SELF_GAIN, k == ACD_CAL_SYS_OFF, k == ACD_CAL_SYS_GAIN};
    `CHK({shorted, ref_on, zero_req, full_req}, req, "cal request")
    n = 0;
    rv = 32'h2;
    while ((rv[ACD_STAT_CAL_BIT] | rv[ACD_STAT_DIV_BIT]) !== 1'b0 && n < 200) begin
      rd(ACD_ADDR_STATUS);
      n++;
    end
    `CHK(n < 200, 1'b1, "calibration hang")
    `CHK({shorted, ref_on, zero_req, full_req}, 4'h0, "cal request drop")
    if (k == ACD_CAL_SELF_OFF || k == ACD_CAL_SYS_OFF) c_off = zv;
    else begin
      span = longint'(signed'(fv)) - longint'(c_off);
      span = (span <= 0) ? 0 : (longint'(1) <<< 46) / span;
      c_gain = (span == 0 || span > 24'hffffff) ? 24'hffffff : span[23:0];
    end
    rd(ACD_ADDR_OFFSET);
    `CHK(rv[23:0], c_off, "offset")
    rd(ACD_ADDR_GAIN);
    `CHK(rv[23:0], c_gain, "gain")
    // Conversions after a calibration keep the filter's word rate used while calibrating.
    send(24'($random(seed)));
    send(24'($random(seed)));
    drain();
  endtask : cal
  initial begin
    #600000;
    `CHK(1'b1, 1'b0, "run timeout")
    test_done();
  end
  initial begin
    {rst_b, push, gap, stall, reg_wr, reg_rd, reg_addr, reg_wdata, push_data} = '0;
    zero_val = 24'h000000;
    full_val = 24'h000001;
    c_off = 24'h000000;
    c_gain = 24'h800000;
    c_code = 2'h0;
    c_uni = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(ACD_ADDR_OFFSET);
    `CHK(rv[23:0], 24'h000000, "offset reset")
    rd(ACD_ADDR_GAIN);
    `CHK(rv[23:0], 24'h800000, "gain reset")
    wr(3'h7, 32'h5a5a5a5a);
    for (int a = 5; a < 8; a++) begin
      rd(a[2:0]);
      `CHK(rv, 32'h0, "unmapped read")
    end
    for (int i = 0; i < 8; i++) begin
      c_code = i[1:0];
      c_uni = i[2];
      gap <= i[0];
      wr(ACD_ADDR_CTRL, {29'h0, c_uni, c_code});
      send(24'h7fffff);
      send(24'h800000);
      send(24'($random(seed)));
      send(24'h000100 << i);
      drain();
    end
    stall <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) send(24'($random(seed)));
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK({raw_valid, raw_ready, res_valid}, 3'b101, "buffer full")
    @(posedge sys_clk);
    stall <= 1'b0;
    drain();
    rd(ACD_ADDR_STATUS);
    `CHK(rv[ACD_STAT_NEW_BIT], 1'b1, "new data flag")
    c_code = 2'h0;
    c_uni = 1'b0;
    wr(ACD_ADDR_CTRL, 32'h0);
    rd(ACD_ADDR_DATA);
    `CHK(rv[15:0], last, "data held")
    rd(ACD_ADDR_STATUS);
    `CHK(rv[ACD_STAT_NEW_BIT], 1'b0, "new data cleared")
    c_off = 24'hfff800;
    c_gain = 24'h600000;
    wr(ACD_ADDR_OFFSET, {8'h0, c_off});
    wr(ACD_ADDR_GAIN, {8'h0, c_gain});
    rd(ACD_ADDR_GAIN);
    `CHK(rv[23:0], c_gain, "gain write")
    send(24'($random(seed)));
    send(24'hfff000);
    drain();
    cal(ACD_CAL_SELF_OFF, 24'h000123, 24'h600123);
    cal(ACD_CAL_SELF_GAIN, 24'h000123, 24'hfff000);
    cal(ACD_CAL_SELF_GAIN, 24'h000123, 24'h600123);
    cal(ACD_CAL_SYS_OFF, 24'hffff00, 24'h7fff00);
    cal(ACD_CAL_SYS_GAIN, 24'hffff00, 24'h7fff00);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
